// >>> hdl/clm_monitor.sv
// load current alarm monitor with apb registers
//
// Local design decisions: register access over APB and the placing of the registers.
`include "clm_defs.svh"
`default_nettype none
module clm_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic heatOn,
    input wire logic ackPin,
    input wire logic sampleValid,
    input wire logic [11:0] sampleRaw,
    output logic [2:0] senseChannelSelect,
    output logic lowLoadAlarmFlag,
    output logic leakageAlarmFlag,
    output logic overcurrentAlarmFlag,
    output logic irq
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic monitorEnable_reg;
    logic [2:0] sel_reg;
    logic [1:0] alarmLatchType_reg;
    logic [15:0] fullScaleRange_reg;
    logic [15:0] lowLoadThreshold_reg;
    logic [15:0] leakageThreshold_reg;
    logic [15:0] overcurrentThreshold_reg;
    logic [2:0] hyst_reg;
    logic [15:0] loadCurrentValue_reg;
    logic [15:0] leakageCurrentValue_reg;
    logic [15:0] lastCurrent_reg;
    logic loadUpd_reg;
    logic leakUpd_reg;
    logic anyUpd_reg;
    logic [1:0] heatSync_reg;
    logic [1:0] ackSync_reg;
    logic ackPinPrev_reg;
    logic ackWr_reg;
    logic [2:0] flagPrev_reg;
    logic [2:0] intStat_reg;
    logic [2:0] intMask_reg;
    logic [2:0] flags;
    logic [2:0] thrOn;
    logic [15:0] thrVec [3];
    logic [15:0] valVec [3];
    logic [2:0] updVec;
    logic [27:0] scaled;
    logic [18:0] marginProd;
    logic [15:0] margin;
    logic ackAll;
    logic wrEn;
    logic rdEn;
    logic [31:0] rdData;
    logic rdHit;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // heat state and acknowledge pin each pass two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            heatSync_reg <= 2'h0;
            ackSync_reg <= 2'h0;
            ackPinPrev_reg <= 1'b0;
        end else begin
            heatSync_reg <= {heatSync_reg[0], heatOn};
            ackSync_reg <= {ackSync_reg[0], ackPin};
            ackPinPrev_reg <= ackSync_reg[1];
        end
    end

    // rising pin edge or software write acknowledges all
    assign ackAll = (ackSync_reg[1] & ~ackPinPrev_reg) | ackWr_reg;

    // ----------------------------------------
    // measurement
    // ----------------------------------------
    // raw code scaled by full scale range, result in tenths
    assign scaled = 28'(sampleRaw) * 28'(fullScaleRange_reg);
    assign marginProd = 19'(fullScaleRange_reg) * 19'(hyst_reg);
    assign margin = 16'(marginProd / 19'd100);

    // sample sorted into load or leakage by heat state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            loadCurrentValue_reg <= 16'h0000;
            leakageCurrentValue_reg <= 16'h0000;
            lastCurrent_reg <= 16'h0000;
            loadUpd_reg <= 1'b0;
            leakUpd_reg <= 1'b0;
            anyUpd_reg <= 1'b0;
        end else begin
            loadUpd_reg <= 1'b0;
            leakUpd_reg <= 1'b0;
            anyUpd_reg <= 1'b0;
            if (monitorEnable_reg && sampleValid) begin
                lastCurrent_reg <= scaled[`CLM_ADC_SHIFT +: 16];
                anyUpd_reg <= 1'b1;
                if (heatSync_reg[1]) begin
                    loadCurrentValue_reg <=
                        scaled[`CLM_ADC_SHIFT +: 16];
                    loadUpd_reg <= 1'b1;
                end else begin
                    leakageCurrentValue_reg <=
                        scaled[`CLM_ADC_SHIFT +: 16];
                    leakUpd_reg <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // alarm channels: 0 low load, 1 leakage, 2 overcurrent
    // ----------------------------------------
    assign thrVec[0] = lowLoadThreshold_reg;
    assign thrVec[1] = leakageThreshold_reg;
    assign thrVec[2] = overcurrentThreshold_reg;
    assign valVec[0] = loadCurrentValue_reg;
    assign valVec[1] = leakageCurrentValue_reg;
    assign valVec[2] = lastCurrent_reg;
    assign updVec = {anyUpd_reg, leakUpd_reg, loadUpd_reg};

    // one comparator and latch per alarm
    for (genvar i = 0; i < 3; i++) begin : gChan
        assign thrOn[i] = monitorEnable_reg &&
            (thrVec[i] != `CLM_THR_OFF);
        clm_alarm_chan #(
            .IS_HIGH(i != 0)
        ) uChan (
            .clk(clk),
            .rst_n(rst_n),
            .active(thrOn[i]),
            .update(updVec[i]),
            .value(valVec[i]),
            .thr(thrVec[i]),
            .margin(margin),
            .latchType(alarmLatchType_reg),
            .ack(ackAll),
            .flag(flags[i])
        );
    end

    // flags to the pins from flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lowLoadAlarmFlag <= 1'b0;
            leakageAlarmFlag <= 1'b0;
            overcurrentAlarmFlag <= 1'b0;
            flagPrev_reg <= 3'h0;
        end else begin
            lowLoadAlarmFlag <= flags[0];
            leakageAlarmFlag <= flags[1];
            overcurrentAlarmFlag <= flags[2];
            flagPrev_reg <= flags;
        end
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    // one wait state so read data comes from a flop
    assign wrEn = psel && penable && pready && pwrite;
    assign rdEn = psel && penable && !pready && !pwrite;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    // read mux
    always_comb begin
        rdData = 32'h0000_0000;
        rdHit = 1'b1;
        case (paddr)
            `CLM_OFS_CTRL: begin
                rdData[`CLM_CTRL_EN_BIT] = monitorEnable_reg;
                rdData[`CLM_CTRL_SEL_MSB:`CLM_CTRL_SEL_LSB] = sel_reg;
                rdData[`CLM_CTRL_LAT_MSB:`CLM_CTRL_LAT_LSB] =
                    alarmLatchType_reg;
            end
            `CLM_OFS_RANGE: rdData[15:0] = fullScaleRange_reg;
            `CLM_OFS_LOWTHR: rdData[15:0] = lowLoadThreshold_reg;
            `CLM_OFS_LEAKTHR: rdData[15:0] = leakageThreshold_reg;
            `CLM_OFS_OCTHR: rdData[15:0] = overcurrentThreshold_reg;
            `CLM_OFS_HYST: rdData[2:0] = hyst_reg;
            `CLM_OFS_ACK: rdData = 32'h0000_0000;
            `CLM_OFS_LOADVAL: rdData[15:0] = loadCurrentValue_reg;
            `CLM_OFS_LEAKVAL: rdData[15:0] = leakageCurrentValue_reg;
            `CLM_OFS_FLAGS: rdData[2:0] = flagPrev_reg;
            `CLM_OFS_ISTAT: rdData[2:0] = intStat_reg;
            `CLM_OFS_IMASK: rdData[2:0] = intMask_reg;
            default: rdHit = 1'b0;
        endcase
    end

    // read data and error answer registered in the wait state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            prdata <= rdEn ? rdData : 32'h0000_0000;
            pslverr <= !rdHit;
        end else begin
            pslverr <= 1'b0;
        end
    end

    // configuration writes, out of range values clamped; bad channel select and latch type written as 0
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            monitorEnable_reg <= 1'b0;
            sel_reg <= 3'h0;
            alarmLatchType_reg <= 2'(clm_pkg::CLM_LAT_NONE);
            fullScaleRange_reg <= `CLM_RANGE_RST;
            lowLoadThreshold_reg <= `CLM_THR_OFF;
            leakageThreshold_reg <= `CLM_THR_OFF;
            overcurrentThreshold_reg <= `CLM_THR_OFF;
            hyst_reg <= `CLM_HYST_RST;
        end else if (wrEn) begin
            case (paddr)
                `CLM_OFS_CTRL: begin
                    monitorEnable_reg <= pwdata[`CLM_CTRL_EN_BIT];
                    sel_reg <= (pwdata[`CLM_CTRL_SEL_MSB:`CLM_CTRL_SEL_LSB]
                        > `CLM_SEL_MAX) ? 3'h0 :
                        pwdata[`CLM_CTRL_SEL_MSB:`CLM_CTRL_SEL_LSB];
                    alarmLatchType_reg <=
                        (pwdata[`CLM_CTRL_LAT_MSB:`CLM_CTRL_LAT_LSB] == 2'h3)
                        ? 2'(clm_pkg::CLM_LAT_NONE)
                        : pwdata[`CLM_CTRL_LAT_MSB:`CLM_CTRL_LAT_LSB];
                end
                `CLM_OFS_RANGE: fullScaleRange_reg <=
                    (pwdata[15:0] > `CLM_RANGE_MAX) ? `CLM_RANGE_MAX
                    : pwdata[15:0];
                `CLM_OFS_LOWTHR: lowLoadThreshold_reg <=
                    (pwdata[15:0] > `CLM_RANGE_MAX) ? `CLM_RANGE_MAX
                    : pwdata[15:0];
                `CLM_OFS_LEAKTHR: leakageThreshold_reg <=
                    (pwdata[15:0] > `CLM_RANGE_MAX) ? `CLM_RANGE_MAX
                    : pwdata[15:0];
                `CLM_OFS_OCTHR: overcurrentThreshold_reg <=
                    (pwdata[15:0] > `CLM_RANGE_MAX) ? `CLM_RANGE_MAX
                    : pwdata[15:0];
                `CLM_OFS_HYST: hyst_reg <=
                    (pwdata[2:0] > `CLM_HYST_MAX) ? `CLM_HYST_MAX
                    : pwdata[2:0];
                default: begin
                end
            endcase
        end
    end

    // acknowledge write makes a one cycle pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ackWr_reg <= 1'b0;
        end else begin
            ackWr_reg <= wrEn && (paddr == `CLM_OFS_ACK) && pwdata[0];
        end
    end

    // channel select driven out from its flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            senseChannelSelect <= 3'h0;
        end else begin
            senseChannelSelect <= sel_reg;
        end
    end

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    // rising flag sets sticky bit, set wins over write one clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            intStat_reg <= 3'h0;
        end else begin
            intStat_reg <= (intStat_reg &
                ~((wrEn && paddr == `CLM_OFS_ISTAT) ? pwdata[2:0] : 3'h0))
                | (flags & ~flagPrev_reg);
        end
    end

    // mask register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            intMask_reg <= 3'h0;
        end else if (wrEn && paddr == `CLM_OFS_IMASK) begin
            intMask_reg <= pwdata[2:0];
        end
    end

    // level interrupt from a flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(intStat_reg & intMask_reg);
        end
    end
endmodule : clm_monitor
`default_nettype wire

// >>> hdl/clm_defs.svh
// constants of the load current alarm monitor
`ifndef CLM_DEFS_SVH
`define CLM_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CLM_OFS_CTRL 8'h00
`define CLM_OFS_RANGE 8'h04
`define CLM_OFS_LOWTHR 8'h08
`define CLM_OFS_LEAKTHR 8'h0c
`define CLM_OFS_OCTHR 8'h10
`define CLM_OFS_HYST 8'h14
`define CLM_OFS_ACK 8'h18
`define CLM_OFS_LOADVAL 8'h1c
`define CLM_OFS_LEAKVAL 8'h20
`define CLM_OFS_FLAGS 8'h24
`define CLM_OFS_ISTAT 8'h28
`define CLM_OFS_IMASK 8'h2c
// ----------------------------------------
// field positions in the control register
// ----------------------------------------
`define CLM_CTRL_EN_BIT 0
`define CLM_CTRL_SEL_LSB 4
`define CLM_CTRL_SEL_MSB 6
`define CLM_CTRL_LAT_LSB 8
`define CLM_CTRL_LAT_MSB 9
// ----------------------------------------
// reset values and limits (currents in tenths)
// ----------------------------------------
`define CLM_RANGE_RST 16'h03e8
`define CLM_RANGE_MAX 16'h2710
`define CLM_HYST_RST 3'h2
`define CLM_HYST_MAX 3'h5
`define CLM_SEL_MAX 3'h4
`define CLM_THR_OFF 16'h0000
`define CLM_ADC_SHIFT 12
`endif

// >>> hdl/clm_pkg.sv
// types of the load current alarm monitor
`default_nettype none
package clm_pkg;
    // alarm latching behaviour
    typedef enum logic [1:0] {
        CLM_LAT_NONE = 2'h0,
        CLM_LAT_AUTO = 2'h1,
        CLM_LAT_MAN = 2'h2
    } clm_latch_t;
endpackage : clm_pkg
`default_nettype wire

// >>> hdl/clm_alarm_chan.sv
// one alarm channel with hysteresis and latching
`default_nettype none
module clm_alarm_chan #(
    parameter bit IS_HIGH = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic active,
    input wire logic update,
    input wire logic [15:0] value,
    input wire logic [15:0] thr,
    input wire logic [15:0] margin,
    input wire logic [1:0] latchType,
    input wire logic ack,
    output logic flag
);
    logic trip;
    logic release_;
    logic cond_reg;
    logic ackSeen_reg;

    // trip and release tests, release needs the hysteresis margin
    always_comb begin
        if (IS_HIGH) begin
            trip = value > thr;
            release_ = ({1'b0, value} + {1'b0, margin}) <= {1'b0, thr};
        end else begin
            trip = value < thr;
            release_ = {1'b0, value} >= ({1'b0, thr} + {1'b0, margin});
        end
    end

    // raw alarm condition, evaluated on each new measurement
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cond_reg <= 1'b0;
        end else if (!active) begin
            cond_reg <= 1'b0;
        end else if (update) begin
            if (trip) begin
                cond_reg <= 1'b1;
            end else if (release_) begin
                cond_reg <= 1'b0;
            end
        end
    end

    // acknowledge remembered for auto reset latching
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ackSeen_reg <= 1'b0;
        end else if (!active || !flag) begin
            ackSeen_reg <= 1'b0;
        end else if (ack) begin
            ackSeen_reg <= 1'b1;
        end
    end

    // flag per latch type
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else if (!active) begin
            flag <= 1'b0;
        end else begin
            case (clm_pkg::clm_latch_t'(latchType))
                clm_pkg::CLM_LAT_NONE: begin
                    flag <= cond_reg;
                end
                clm_pkg::CLM_LAT_AUTO: begin
                    if (cond_reg) begin
                        flag <= 1'b1;
                    end else if (ackSeen_reg || ack) begin
                        flag <= 1'b0;
                    end
                end
                clm_pkg::CLM_LAT_MAN: begin
                    if (cond_reg) begin
                        flag <= 1'b1;
                    end else if (ack) begin
                        flag <= 1'b0;
                    end
                end
                default: begin
                    flag <= cond_reg;
                end
            endcase
        end
    end
endmodule : clm_alarm_chan
`default_nettype wire

// >>> sim/clm_monitor_asserts.sv
// port assertions of the load current alarm monitor
`include "clm_defs.svh"
`default_nettype none
module clm_monitor_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sampleValid,
    input wire logic lowLoadAlarmFlag,
    input wire logic leakageAlarmFlag,
    input wire logic overcurrentAlarmFlag,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------
    // bus shadow
    // ------------
    logic wrDone;
    logic enReg;
    logic lowOffReg;
    logic ocOffReg;
    logic maskOffReg;
    // a completed write to a mapped register
    assign wrDone = psel && penable && pwrite && pready && !pslverr;
    // follow enable, threshold off and mask state from the bus
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enReg <= 1'b0;
            lowOffReg <= 1'b1;
            ocOffReg <= 1'b1;
            maskOffReg <= 1'b1;
        end else if (wrDone) begin
            case (paddr)
                `CLM_OFS_CTRL: enReg <= pwdata[`CLM_CTRL_EN_BIT];
                `CLM_OFS_LOWTHR: lowOffReg <= pwdata == 32'h0;
                `CLM_OFS_OCTHR: ocOffReg <= pwdata == 32'h0;
                `CLM_OFS_IMASK: maskOffReg <= pwdata[2:0] == 3'h0;
                default: ;
            endcase
        end
    end
    // ------------
    // properties
    // ------------
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    chk_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered after one wait state");
    chk_err_map: assert property (
        pready |-> pslverr == (paddr > `CLM_OFS_IMASK))
        else $error("pslverr does not match the address map");
    chk_dis_quiet: assert property (
        !enReg [*4] |-> !(lowLoadAlarmFlag || leakageAlarmFlag ||
        overcurrentAlarmFlag)) else $error("alarm flag while disabled");
    chk_low_off: assert property (
        lowOffReg [*4] |-> !lowLoadAlarmFlag)
        else $error("low load flag with threshold off");
    chk_oc_off: assert property (
        ocOffReg [*4] |-> !overcurrentAlarmFlag)
        else $error("overcurrent flag with threshold off");
    chk_low_cause: assert property (
        $rose(lowLoadAlarmFlag) |-> $past(sampleValid, 3) ||
        $past(sampleValid, 4) || $past(sampleValid, 5))
        else $error("low load flag rose without a sample");
    chk_oc_cause: assert property (
        $rose(overcurrentAlarmFlag) |-> $past(sampleValid, 3) ||
        $past(sampleValid, 4) || $past(sampleValid, 5))
        else $error("overcurrent flag rose without a sample");
    chk_irq_masked: assert property (maskOffReg [*3] |-> !irq)
        else $error("interrupt while all masked");
    cov_low: cover property ($rose(lowLoadAlarmFlag));
    cov_leak: cover property ($rose(leakageAlarmFlag));
    cov_oc: cover property ($rose(overcurrentAlarmFlag));
    cov_irq: cover property ($rose(irq));
endmodule : clm_monitor_asserts
bind clm_monitor clm_monitor_asserts chk (.clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .sampleValid,
    .lowLoadAlarmFlag, .leakageAlarmFlag, .overcurrentAlarmFlag, .irq);
`default_nettype wire

// >>> sim/clm_ct_model.sv
// current transformer model feeding converter samples
`default_nettype none
module clm_ct_model #(
    parameter int SLOW_GAP = 9
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic heatOn,
    input wire logic [2:0] senseChannelSelect,
    input wire logic [11:0] onLevel,
    input wire logic [11:0] offLevel,
    output logic sampleValid,
    output logic [11:0] sampleRaw
);
    timeunit 1ns;
    timeprecision 1ns;
    int gapCnt;
    logic slow;
    // samples alternate prompt and slow spacing; stale data toggles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gapCnt <= 0;
            slow <= 1'b0;
            sampleValid <= 1'b0;
            sampleRaw <= 12'h000;
        end else if (senseChannelSelect == 3'h0 || gapCnt != 0) begin
            sampleValid <= 1'b0;
            sampleRaw <= ~sampleRaw; // no valid conversion on the line
            gapCnt <= (gapCnt == 0) ? 0 : gapCnt - 1;
        end else begin
            sampleValid <= 1'b1;
            sampleRaw <= heatOn ? onLevel : offLevel;
            gapCnt <= slow ? SLOW_GAP : 1;
            slow <= ~slow;
        end
    end
endmodule : clm_ct_model
`default_nettype wire

// >>> sim/clm_tb.sv
// self-checking bench of the load current alarm monitor
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MRG = 32'h1000 * 32'h2 / 32'h64; // margin in tenths
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic heatOn = 1'b1;
    logic ackPin = 1'b0;
    logic sampleValid;
    logic [11:0] sampleRaw;
    logic [2:0] senseChannelSelect;
    logic lowFlag;
    logic leakFlag;
    logic ocFlag;
    logic irq;
    logic [11:0] onLevel = 12'h000;
    logic [11:0] offLevel = 12'h000;
    logic [31:0] rnd = 32'h019dca50;
    logic [7:0] dAdr [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
        8'h2c, 8'h24};
    logic [31:0] dVal [8] = '{32'h0, 32'h3e8, 32'h0, 32'h0, 32'h0, 32'h2,
        32'h0, 32'h0};
    int lowSeq [4] = '{12'h190, 12'h23a, 12'h245, 12'h190};
    int leakSeq [4] = '{12'h12c, 12'h096, 12'h064, 12'h12c};
    int errCount = 0;
    int totalChecks = 0;
    int prev;
    // ------------
    // clock, design and far side
    // ------------
    always #10 clk = ~clk;
    clm_monitor dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .heatOn, .ackPin,
        .sampleValid, .sampleRaw, .senseChannelSelect,
        .lowLoadAlarmFlag(lowFlag), .leakageAlarmFlag(leakFlag),
        .overcurrentAlarmFlag(ocFlag), .irq);
    clm_ct_model ct (.clk, .rst_n, .heatOn, .senseChannelSelect,
        .onLevel, .offLevel, .sampleValid, .sampleRaw);
    // ------------
    // tasks and reference
    // ------------
    task automatic closeOut();
        if (errCount == 0 && totalChecks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : closeOut
    task automatic cmp(input string n, input logic [31:0] e,
                       input logic [31:0] s);
        totalChecks++;
        if (s !== e) begin
            errCount++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : cmp
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    // flag with exit hysteresis, high or low alarm
    function automatic int hyst(int p, int v, int t, bit hi);
        if (t == 0) return 0;
        if (hi ? v > t : v < t) return 1;
        if (hi ? v + MRG <= t : v >= t + MRG) return 0;
        return p;
    endfunction : hyst
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            errCount++;
            closeOut();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        cmp("read data", v, q);
        cmp("slverr", {31'h0, a > 8'h2c}, {31'h0, e});
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    // wait for three fresh samples, then for the flag pipeline
    task automatic settle();
        int n;
        int k;
        n = 0;
        k = 0;
        while (k < 3 && n < 200) begin
            @(posedge clk);
            n++;
            if (sampleValid === 1'b1) k++;
        end
        if (k < 3) begin
            errCount++;
            closeOut();
        end
        repeat (6) @(posedge clk);
    endtask : settle
    task automatic ack();
        ackPin <= 1'b1;
        repeat (4) @(posedge clk);
        ackPin <= 1'b0;
        settle();
    endtask : ack
    // ------------
    // main sequence
    // ------------
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) rd(dAdr[i], dVal[i]);
        rd(8'h30, 32'h0);
        rnd = lfsr(rnd);
        onLevel <= rnd[11:0];
        offLevel <= rnd[27:16];
        wr(8'h00, 32'h11);
        settle();
        cmp("channel", 32'h1, {29'h0, senseChannelSelect});
        rd(8'h1c, 32'(rnd[11:0]) * 32'h3e8 >> 12);
        heatOn <= 1'b0;
        settle();
        rd(8'h20, 32'(rnd[27:16]) * 32'h3e8 >> 12);
        wr(8'h04, 32'h1000);
        wr(8'h2c, 32'h1);
        wr(8'h08, 32'h1f4);
        heatOn <= 1'b1;
        prev = 0;
        foreach (lowSeq[i]) begin
            onLevel <= lowSeq[i][11:0];
            settle();
            prev = hyst(prev, lowSeq[i], 32'h1f4, 1'b0);
            cmp("low flag", prev, {31'h0, lowFlag});
        end
        cmp("irq", 32'h1, {31'h0, irq});
        rd(8'h28, 32'h1);
        wr(8'h28, 32'h1);
        repeat (3) @(posedge clk);
        cmp("irq", 32'h0, {31'h0, irq});
        rd(8'h28, 32'h0);
        wr(8'h08, 32'h0);
        repeat (4) @(posedge clk);
        cmp("low flag", 32'h0, {31'h0, lowFlag});
        wr(8'h10, 32'h3e8);
        for (int lt = 0; lt < 4; lt++) begin
            // fourth pass repeats manual latching, acked by register write
            wr(8'h00, 32'h11 | ((lt == 3 ? 2 : lt) << 8));
            onLevel <= 12'h44c;
            settle();
            cmp("oc flag", 32'h1, {31'h0, ocFlag});
            rd(8'h24, 32'h4);
            ack();
            cmp("oc flag", 32'h1, {31'h0, ocFlag});
            onLevel <= 12'h384;
            settle();
            cmp("oc flag", lt >= 2, {31'h0, ocFlag});
            if (lt == 3) begin
                wr(8'h18, 32'h1);
                settle();
            end else begin
                ack();
            end
            cmp("oc flag", 32'h0, {31'h0, ocFlag});
        end
        wr(8'h00, 32'h11);
        wr(8'h0c, 32'hc8);
        onLevel <= 12'h12c;
        settle();
        cmp("leak flag", 32'h0, {31'h0, leakFlag});
        heatOn <= 1'b0;
        prev = 0;
        foreach (leakSeq[i]) begin
            offLevel <= leakSeq[i][11:0];
            settle();
            prev = hyst(prev, leakSeq[i], 32'hc8, 1'b1);
            cmp("leak flag", prev, {31'h0, leakFlag});
        end
        cmp("irq", 32'h0, {31'h0, irq});
        wr(8'h00, 32'h0);
        repeat (4) @(posedge clk);
        cmp("leak flag", 32'h0, {31'h0, leakFlag});
        rd(8'h24, 32'h0);
        closeOut();
    end
endmodule : testbench
`default_nettype wire
